// file: rtl/adc_cfg_pkg.sv
package adc_cfg_pkg;

  // ==========================================================
  // register map
  localparam logic [1:0] ADDR_INPUT_REF_CLOCK_CFG = 2'h0;
  localparam logic [1:0] ADDR_CHANNEL_SELECT      = 2'h1;
  localparam int unsigned ADDR_W = 2;
  localparam int unsigned DATA_W = 8;

  localparam logic [7:0] CFG_RESET     = 8'h00;
  localparam logic [4:0] CHANNEL_RESET = 5'h0_0;

  // ==========================================================
  // field positions in adc_input_ref_clock_cfg and the channel select register
  localparam int unsigned INSRC_LSB = 5;
  localparam int unsigned INSRC_MSB = 7;
  localparam int unsigned REFSEL_LSB = 3;
  localparam int unsigned REFSEL_MSB = 4;
  localparam int unsigned CKDIV_LSB = 0;
  localparam int unsigned CKDIV_MSB = 2;
  localparam int unsigned CHAN_MSB = 4;

  // ==========================================================
  // encodings
  localparam logic [2:0] INSRC_EXT0     = 3'h0;
  localparam logic [2:0] INSRC_BANDGAP  = 3'h1;
  localparam logic [2:0] INSRC_RSV_LO   = 3'h2;
  localparam logic [2:0] INSRC_RSV_HI   = 3'h4;
  localparam logic [1:0] REFSEL_SUPPLY  = 2'h1;
  localparam logic [4:0] CHAN_LAST      = 5'h1_7;
  localparam int unsigned CHAN_COUNT    = 24;
  localparam int unsigned DIV_MAX_W     = 7;

  typedef enum {
    SRC_EXTERNAL,
    SRC_BANDGAP,
    SRC_GROUND
  } input_route_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_t;

  typedef struct packed {
    logic                  route_ext;
    logic                  route_bandgap;
    logic                  route_ground;
    logic                  ref_from_supply;
    logic                  ref_from_pin;
    logic                  channel_valid;
    logic [CHAN_COUNT-1:0] channel_onehot;
  } analog_ctrl_t;

endpackage

// file: rtl/adc_input_ref_clock_select.sv
`timescale 1ns/1ps
`default_nettype none

// Operation
// RULE1 - input codes 000 and 101..111 route the selected external channel
// RULE2 - input code 001 routes the internal bandgap voltage to the converter
// RULE3 - input codes 010..100 are reserved and ground the converter input
// RULE4 - software picks channel 11000..11111 whenever bandgap input is used
// RULE5 - reference code 01 picks analog supply; 00 or 1x picks the pin
// RULE6 - software keeps reference pin function off when supply is reference
// RULE7 - conversion clock is system clock divided by two to the field value
// RULE8 - channel codes 00000..10111 connect analog channels 0 to 23
// RULE9 - channel codes 11000..11111 leave the external input floating
// RULE10 - channel register bits 7..5 ignore writes and read as zero
// RULE11 - software keeps conversion clock period within 0.5 to 10 us
// RULE12 - all fields clear on reset and are readable and writable
module adc_input_ref_clock_select (
  input  wire logic                      clock_i,
  input  wire logic                      srst_i,
  input  wire adc_cfg_pkg::reg_req_t     req_i,
  output var  logic [7:0]                rdata_o,
  output var  adc_cfg_pkg::analog_ctrl_t ctrl_o,
  output var  logic                      conv_clk_o
);
  import adc_cfg_pkg::*;

  // ==========================================================
  // local constants
  localparam logic [2:0]           CKDIV_UNDIV  = 3'h0;
  localparam logic [2:0]           CKDIV_STEP   = 3'h1;
  localparam logic [7:0]           RDATA_IDLE   = 8'h00;
  localparam logic [2:0]           CHAN_PAD     = 3'h0;
  localparam logic [7:0]           MASK_ONE     = 8'h01;
  localparam logic [DIV_MAX_W-1:0] DIV_ALL_ONES = '1;
  localparam logic [DIV_MAX_W-1:0] DIV_STEP     = 7'h01;
  // reset values of the packed configuration fields
  localparam logic [2:0] INSRC_RESET  = CFG_RESET[INSRC_MSB:INSRC_LSB];
  localparam logic [1:0] REFSEL_RESET = CFG_RESET[REFSEL_MSB:REFSEL_LSB];
  localparam logic [2:0] CKDIV_RESET  = CFG_RESET[CKDIV_MSB:CKDIV_LSB];
  localparam analog_ctrl_t CTRL_RESET = '0;

  // ==========================================================
  // request fields; the slave never stalls, so there is no ready
  wire logic [ADDR_W-1:0] req_addr;
  wire logic [DATA_W-1:0] req_wdata;
  wire logic              req_wr;
  wire logic              req_rd;

  assign req_addr  = req_i.addr;
  assign req_wdata = req_i.wdata;
  assign req_wr    = req_i.wr;
  assign req_rd    = req_i.rd;

  // ==========================================================
  // bus decode
  wire logic addr_cfg;
  wire logic addr_chan;
  wire logic wr_cfg;
  wire logic wr_chan;

  assign addr_cfg  = (req_addr == ADDR_INPUT_REF_CLOCK_CFG);
  assign addr_chan = (req_addr == ADDR_CHANNEL_SELECT);
  assign wr_cfg    = req_wr && addr_cfg;
  assign wr_chan   = req_wr && addr_chan;

  // ==========================================================
  // register file state
  logic [2:0]           insrc_reg;
  logic [2:0]           insrc_next;
  logic [1:0]           refsel_reg;
  logic [1:0]           refsel_next;
  logic [2:0]           ckdiv_reg;
  logic [2:0]           ckdiv_next;
  logic [4:0]           chan_reg;
  logic [4:0]           chan_next;
  logic [7:0]           rdata_reg;
  logic [7:0]           rdata_next;
  logic [DIV_MAX_W-1:0] div_cnt_reg;
  logic [DIV_MAX_W-1:0] div_cnt_next;
  logic                 conv_clk_reg;
  logic                 conv_clk_next;
  analog_ctrl_t         ctrl_reg;
  analog_ctrl_t         ctrl_next;

  // ==========================================================
  // write path: a field keeps its value unless written
  // writes to unmapped indexes change nothing
  assign insrc_next  = wr_cfg ? req_wdata[INSRC_MSB:INSRC_LSB]
                              : insrc_reg; // RULE12
  assign refsel_next = wr_cfg ? req_wdata[REFSEL_MSB:REFSEL_LSB]
                              : refsel_reg; // RULE12
  assign ckdiv_next  = wr_cfg ? req_wdata[CKDIV_MSB:CKDIV_LSB]
                              : ckdiv_reg; // RULE12
  // upper channel register bits have no storage
  assign chan_next   = wr_chan ? req_wdata[CHAN_MSB:0]
                               : chan_reg; // RULE10

  // ==========================================================
  // configuration registers
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      insrc_reg <= INSRC_RESET; // RULE12
    end else begin
      insrc_reg <= insrc_next;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      refsel_reg <= REFSEL_RESET; // RULE12
    end else begin
      refsel_reg <= refsel_next;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ckdiv_reg <= CKDIV_RESET; // RULE12
    end else begin
      ckdiv_reg <= ckdiv_next;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      chan_reg <= CHANNEL_RESET; // RULE12
    end else begin
      chan_reg <= chan_next;
    end
  end

  // ==========================================================
  // read path: unmapped indexes read as zero
  wire logic [7:0] cfg_view;
  wire logic [7:0] chan_view;
  wire logic [7:0] rd_mux;

  assign cfg_view   = {insrc_reg, refsel_reg, ckdiv_reg}; // RULE12
  assign chan_view  = {CHAN_PAD, chan_reg}; // RULE10
  assign rd_mux     = addr_cfg  ? cfg_view  :
                      addr_chan ? chan_view :
                      RDATA_IDLE;
  assign rdata_next = req_rd ? rd_mux : RDATA_IDLE;

  // ==========================================================
  // read data register: stands one cycle after the read strobe
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rdata_reg <= RDATA_IDLE;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata_o = rdata_reg;

  // ==========================================================
  // input routing: reserved codes fall through to ground
  wire logic    src_bandgap;
  wire logic    src_reserved;
  wire logic    src_external;
  input_route_t route;

  assign src_bandgap  = (insrc_reg == INSRC_BANDGAP); // RULE2
  assign src_reserved = (insrc_reg >= INSRC_RSV_LO) &&
                        (insrc_reg <= INSRC_RSV_HI); // RULE3
  assign src_external = !src_bandgap && !src_reserved; // RULE1

  always_comb begin
    route = SRC_GROUND;
    if (src_bandgap) begin
      route = SRC_BANDGAP; // RULE2
    end else if (src_external) begin
      route = SRC_EXTERNAL; // RULE1
    end
  end

  // ==========================================================
  // reference choice
  wire logic ref_supply;
  wire logic ref_pin;

  assign ref_supply = (refsel_reg == REFSEL_SUPPLY); // RULE5
  assign ref_pin    = !ref_supply; // RULE5

  // ==========================================================
  // channel decode
  // codes past the last channel match no cell: input floats
  wire logic [CHAN_COUNT-1:0] chan_hit;
  wire logic                  chan_exists;

  for (genvar g = 0; g < CHAN_COUNT; g++) begin : g_chan
    adc_chan_match #(
      .CODE (5'(g))
    ) u_match (
      .code_i (chan_reg),
      .hit_o  (chan_hit[g])
    ); // RULE8
  end

  assign chan_exists = (chan_reg <= CHAN_LAST); // RULE9

  // ==========================================================
  // analog control word
  always_comb begin
    ctrl_next = CTRL_RESET;
    case (route)
      SRC_EXTERNAL: begin
        ctrl_next.route_ext = 1'b1; // RULE1
      end
      SRC_BANDGAP: begin
        ctrl_next.route_bandgap = 1'b1; // RULE2
      end
      SRC_GROUND: begin
        ctrl_next.route_ground = 1'b1; // RULE3
      end
      default: begin
        ctrl_next.route_ground = 1'b1;
      end
    endcase
    ctrl_next.ref_from_supply = ref_supply; // RULE5
    ctrl_next.ref_from_pin    = ref_pin; // RULE5
    ctrl_next.channel_valid   = chan_exists; // RULE9
    ctrl_next.channel_onehot  = chan_hit; // RULE8
  end

  // ==========================================================
  // control register
  // control outputs change one cycle after a register does
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ctrl_reg <= CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  assign ctrl_o = ctrl_reg;

  // ==========================================================
  // conversion clock divider
  // half period is two to the code less one cycles
  // counter free runs: a code change does not restart phase
  wire logic                 clk_undivided;
  wire logic                 div_active;
  wire logic [2:0]           div_shift;
  wire logic [7:0]           div_span;
  wire logic [DIV_MAX_W-1:0] div_mask;
  wire logic                 div_wrap;

  assign clk_undivided = (ckdiv_reg == CKDIV_UNDIV); // RULE7
  assign div_active    = !clk_undivided;
  assign div_shift     = ckdiv_reg - CKDIV_STEP;
  assign div_span      = (MASK_ONE << div_shift) - MASK_ONE;
  assign div_mask      = div_span[DIV_MAX_W-1:0];
  assign div_wrap      = ((div_cnt_reg | ~div_mask) == DIV_ALL_ONES);
  assign div_cnt_next  = div_cnt_reg + DIV_STEP;
  assign conv_clk_next = (div_active && div_wrap)
                         ? ~conv_clk_reg : conv_clk_reg; // RULE7

  // ==========================================================
  // divider registers
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      div_cnt_reg <= '0;
    end else begin
      div_cnt_reg <= div_cnt_next;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      conv_clk_reg <= 1'b0;
    end else begin
      conv_clk_reg <= conv_clk_next;
    end
  end

  // ==========================================================
  // clock output: code 000 passes the system clock itself
  assign conv_clk_o = clk_undivided ? clock_i : conv_clk_reg; // RULE7

endmodule // adc_input_ref_clock_select

// ==========================================================
// channel match cell
module adc_chan_match #(
  parameter int unsigned       CODE_W = 5,
  parameter logic [CODE_W-1:0] CODE   = 5'h00
) (
  input  wire logic [CODE_W-1:0] code_i,
  output var  logic              hit_o
);

  wire logic code_equal;

  assign code_equal = (code_i == CODE);
  assign hit_o      = code_equal;

endmodule // adc_chan_match

`default_nettype wire

// file: sim/adc_input_ref_clock_select_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// port checker
module adc_cfg_sva (
  input wire logic                      clock_i,
  input wire logic                      srst_i,
  input wire adc_cfg_pkg::reg_req_t     req_i,
  input wire logic [7:0]                rdata_o,
  input wire adc_cfg_pkg::analog_ctrl_t ctrl_o,
  input wire logic                      conv_clk_o
);
  import adc_cfg_pkg::*;
  wire       wc = req_i.wr && req_i.addr == 2'h0;
  wire       wn = req_i.wr && req_i.addr == 2'h1;
  wire [2:0] s  = req_i.wdata[7:5];
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  a_rd_idle_zero: assert property (
    !$past(req_i.rd) |-> rdata_o == 8'h00) else $error("rdata not idle");
  a_chan_upper_zero: assert property (
    $past(req_i.rd) && $past(req_i.addr) == 2'h1 |-> rdata_o[7:5] == 3'h0)
    else $error("channel upper bits set");
  a_cfg_read_back: assert property (
    wc ##1 (req_i.rd && req_i.addr == 2'h0) |=>
    rdata_o == $past(req_i.wdata, 2)) else $error("cfg read back");
  a_src_external: assert property (
    wc && (s == 3'h0 || s > 3'h4) |-> ##2 ctrl_o.route_ext)
    else $error("no external route");
  a_src_bandgap: assert property (
    wc && s == 3'h1 |-> ##2 ctrl_o.route_bandgap) else $error("no bandgap");
  a_src_ground: assert property (
    wc && s inside {[3'h2:3'h4]} |-> ##2 ctrl_o.route_ground)
    else $error("no ground");
  a_ref_select: assert property (
    wc |-> ##2 ctrl_o.ref_from_supply == ($past(req_i.wdata[4:3], 2) == 2'h1))
    else $error("reference choice");
  a_chan_onehot: assert property (
    wn |-> ##2 ctrl_o.channel_onehot ==
    24'h00_0001 << $past(req_i.wdata[4:0], 2)) else $error("channel onehot");
  a_chan_float: assert property (
    wn |-> ##2 ctrl_o.channel_valid == ($past(req_i.wdata[4:0], 2) < 5'h18))
    else $error("channel valid");
  a_div_two: assert property (
    wc && req_i.wdata[2:0] == 3'h1 ##1 !wc [*4] |->
    conv_clk_o != $past(conv_clk_o)) else $error("divide by two");
  c_bandgap: cover property (wc && s == 3'h1);
  c_last_chan: cover property (wn && req_i.wdata[4:0] == 5'h17);
  c_read_back: cover property (wc ##1 req_i.rd);
endmodule // adc_cfg_sva

bind adc_input_ref_clock_select adc_cfg_sva u_sva (
  .clock_i(clock_i), .srst_i(srst_i), .req_i(req_i),
  .rdata_o(rdata_o), .ctrl_o(ctrl_o), .conv_clk_o(conv_clk_o));
`default_nettype wire

// file: sim/adc_input_ref_clock_select_tb.sv
`timescale 1ns/1ps
`default_nettype none
module adc_input_ref_clock_select_tb;
  import adc_cfg_pkg::*;
  logic         clock_i = 1'b0;
  logic         srst_i  = 1'b1;
  reg_req_t     req_i   = '0;
  logic [7:0]   rdata_o;
  analog_ctrl_t ctrl_o;
  logic         conv_clk_o;
  int           error_cnt = 0;
  int           checks    = 0;
  int           n;
  logic         prev;
  always #5 clock_i = ~clock_i;
  adc_input_ref_clock_select dut (.clock_i(clock_i), .srst_i(srst_i),
    .req_i(req_i), .rdata_o(rdata_o), .ctrl_o(ctrl_o),
    .conv_clk_o(conv_clk_o));
  // ====
  // bus and compare tasks
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic op(input logic [1:0] a, input logic [7:0] d,
                    input logic w, r);
    req_i <= '{a, d, w, r};
    @(posedge clock_i);
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    op(a, 8'h00, 1'b0, 1'b1);
    req_i <= '0;
    #1 chk("rdata", e, rdata_o);
    @(posedge clock_i);
  endtask
  task automatic complete_run;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ====
  // scenarios
  initial begin
    repeat (8) @(posedge clock_i);
    srst_i <= 1'b0;
    @(negedge clock_i);
    #2 chk("cclk", 0, conv_clk_o);
    @(posedge clock_i);
    rd(2'h0, 8'h00);
    rd(2'h1, 8'h00);
    chk("ctrl", 32'h2300_0001, ctrl_o);
    op(2'h1, 8'h18, 1'b1, 1'b0);
    for (int k = 0; k < 8; k++) begin
      op(2'h0, {k[2:0], k[1:0], 3'h0}, 1'b1, 1'b0);
      rd(2'h0, {k[2:0], k[1:0], 3'h0});
      chk("route", k == 1 ? 3'h2 : (k inside {[2:4]} ? 3'h1 : 3'h4),
          ctrl_o[29:27]);
      chk("ref", k[1:0] == 2'h1 ? 2'h2 : 2'h1, ctrl_o[26:25]);
    end
    for (int c = 0; c < 32; c++) begin
      op(2'h1, {3'h7, c[4:0]}, 1'b1, 1'b0);
      rd(2'h1, {3'h0, c[4:0]});
      chk("onehot", c < 24 ? 24'h00_0001 << c : 0,
          ctrl_o.channel_onehot);
      chk("valid", c < 24, ctrl_o.channel_valid);
    end
    op(2'h2, 8'hff, 1'b1, 1'b0);
    rd(2'h3, 8'h00);
    rd(2'h0, 8'hf8);
    for (int k = 1; k < 8; k++) begin
      op(2'h0, {5'h00, k[2:0]}, 1'b1, 1'b0);
      repeat (8) op(2'h0, 8'h00, 1'b0, 1'b0);
      n = 0;
      prev = conv_clk_o;
      repeat (256) begin
        @(negedge clock_i);
        n += int'(conv_clk_o && !prev);
        prev = conv_clk_o;
      end
      @(posedge clock_i);
      chk("cclk_rise", 256 >> k, n);
    end
    complete_run();
  end
  initial begin
    #200000;
    error_cnt++;
    complete_run();
  end
endmodule // adc_input_ref_clock_select_tb
`default_nettype wire
